/* File: rtl/host_port_output_steering.sv */
// Host port bus steering between register access and result output
`timescale 1ns/10ps
`include "host_port_regs.svh"
// Functional notes
// R1 - Selected, read low, write high: drive register contents on shared bus.
// R2 - Selected, write low, read high, output enable high: bus takes write data.
// R3 - Deselected with output enable low: drive conversion result, ignore strobes.
// R4 - Output enable high and no read: data outputs float.
// R5 - Host never asserts both strobes, nor enable low while selected without read.
// R6 - Chip select active low; strobes act only while it is low.
// R7 - Twelve-bit variant: 12-bit result, low eight bits shared with register bus.
// R8 - Ten-bit variant: result bit 0 on register bus bit 2; bits 0,1 register only.
// R9 - Host supplies per-pixel gain coefficient, 12 or 10 bits, MSB highest.
// R10 - Host supplies per-pixel 8-bit offset coefficient, bit 7 MSB.
// R11 - Timing logic drives line start at each scan line beginning.
// R12 - Timing logic supplies reset sample, level sample and conversion clocks.
// R13 - Register select picks the register a read or write reaches.
// R14 - Select codes: config, config2, gain, odd, even, input offset, reserved, Bayer.
// R15 - Write data and select captured on write strobe rising edge while selected.
module host_port_output_steering #(
  parameter int RESULT_W = 12
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                chip_sel_n,
  input  wire logic                rd_strobe_n,
  input  wire logic                wr_strobe_n,
  input  wire logic                out_en_n,
  input  wire logic [2:0]          reg_sel,
  input  wire logic [7:0]          hostRegBusIn,
  output      logic [7:0]          hostRegBusOut,
  output      logic [7:0]          hostRegBusOe,
  output      logic [3:0]          resultHighOut,
  output      logic [3:0]          resultHighOe,
  input  wire logic [RESULT_W-1:0] convResult,
  input  wire logic [RESULT_W-1:0] gainCoef,
  input  wire logic [7:0]          offsetCoef,
  input  wire logic                line_start,
  input  wire logic                reset_sample_pulse,
  input  wire logic                level_sample_pulse,
  input  wire logic                conv_clk,
  output      logic [2:0]          bayerCtrlOut
);
  import host_port_pkg::*;

  // ==========================================
  // Pin synchronisers
  logic [3:0]          ctlMeta_q;
  logic [3:0]          ctlSync_q;
  logic [2:0]          selMeta_q;
  logic [2:0]          selSync_q;
  logic [7:0]          datMeta_q;
  logic [7:0]          datSync_q;
  logic                wrPrev_q;
  logic [RESULT_W-1:0] resMeta_q;
  logic [RESULT_W-1:0] resSync_q;

  // Control pins; history seeds high so reset release is no write edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctlMeta_q <= 4'hF;
      ctlSync_q <= 4'hF;
      wrPrev_q  <= 1'b1;
    end else begin
      ctlMeta_q <= {chip_sel_n, rd_strobe_n, wr_strobe_n, out_en_n};
      ctlSync_q <= ctlMeta_q;
      wrPrev_q  <= ctlSync_q[1];
    end
  end

  // Select and data; host keeps them steady well before the strobe rises
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selMeta_q <= 3'h0;
      selSync_q <= 3'h0;
      datMeta_q <= 8'h00;
      datSync_q <= 8'h00;
    end else begin
      selMeta_q <= reg_sel;
      selSync_q <= selMeta_q;
      datMeta_q <= hostRegBusIn;
      datSync_q <= datMeta_q;
    end
  end

  // Result word; a word changing mid-sample may show one mixed value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resMeta_q <= '0;
      resSync_q <= '0;
    end else begin
      resMeta_q <= convResult;
      resSync_q <= resMeta_q;
    end
  end

  logic csN;
  logic rdN;
  logic wrN;
  logic oeN;
  assign csN = ctlSync_q[3];
  assign rdN = ctlSync_q[2];
  assign wrN = ctlSync_q[1];
  assign oeN = ctlSync_q[0];

  // ==========================================
  // Register file
  host_strobe_if strobes ();

  // Rising write edge after the synchroniser; a pulse under one clock may be lost
  logic wrRise;
  always_comb begin
    wrRise = wrN && !wrPrev_q; // R15
  end

  // Strobes count only while selected
  assign strobes.writeStrobe = !csN && wrRise; // R6 R2
  assign strobes.regSel      = selSync_q; // R14
  assign strobes.writeData   = datSync_q; // R2
  assign strobes.readSel     = selSync_q; // R13

  host_reg_file u_regs (
    .clk    (clk),
    .resetn (resetn),
    .bus    (strobes.regs)
  );

  // ==========================================
  // Mode decode
  function automatic bus_mode_type decodeMode(input logic cs, input logic rd, input logic wr, input logic oe);
    if (!cs && !rd && wr) begin
      decodeMode = MODE_REG_READ; // R1
    end else if (!cs && rd && !wr && oe) begin
      decodeMode = MODE_REG_WRITE; // R2
    end else if (cs && !oe) begin
      decodeMode = MODE_RESULT_OUT; // R3
    end else begin
      decodeMode = MODE_IDLE; // R4
    end
  endfunction : decodeMode

  bus_mode_type        mode;
  logic [7:0]          busOut_d;
  logic [7:0]          busOe_d;
  logic [3:0]          hiOut_d;
  logic [3:0]          hiOe_d;
  logic [7:0]          lowRes;

  // Ten-bit parts keep lanes 1:0 for register traffic only
  localparam logic [7:0] RES_LANES = (RESULT_W == 12) ? 8'hFF : 8'hFC;

  // Place the result bits that share the register bus lanes
  always_comb begin
    lowRes = 8'h00;
    if (RESULT_W == 12) begin
      lowRes = resSync_q[7:0]; // R7
    end else begin
      lowRes = {resSync_q[5:0], 2'b00}; // R8
    end
  end

  always_comb begin
    mode     = decodeMode(csN, rdN, wrN, oeN);
    busOut_d = 8'h00;
    busOe_d  = 8'h00;
    hiOut_d  = '0;
    hiOe_d   = '0;
    unique case (mode)
      MODE_REG_READ: begin
        busOut_d = strobes.readData; // R1
        busOe_d  = 8'hFF;
      end
      MODE_RESULT_OUT: begin
        busOut_d = lowRes; // R3
        busOe_d  = RES_LANES; // R8
        hiOut_d  = resSync_q[RESULT_W-1 -: 4]; // R7 R8
        hiOe_d   = '1; // R7
      end
      MODE_REG_WRITE: begin
        busOe_d = 8'h00; // R2
      end
      MODE_IDLE: begin
        busOe_d = 8'h00; // R4
      end
    endcase
  end

  // ==========================================
  // Pixel-order control
  logic [2:0] bayerCtrl_d;

  // Only three low bits matter here; the full byte stays readable in the register file
  always_comb begin
    bayerCtrl_d = bayerCtrlOut;
    if (selSync_q == `SEL_BAYER && strobes.writeStrobe) begin
      bayerCtrl_d = datSync_q[2:0]; // R14 R15
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bayerCtrlOut <= 3'h0;
    end else begin
      bayerCtrlOut <= bayerCtrl_d;
    end
  end

  // ==========================================
  // Output registers
  // Unused coefficient and timing pins stay unread; the datapath lives elsewhere
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hostRegBusOut <= 8'h00;
      hostRegBusOe  <= 8'h00;
      resultHighOut <= '0;
      resultHighOe  <= '0;
    end else begin
      hostRegBusOut <= busOut_d;
      hostRegBusOe  <= busOe_d;
      resultHighOut <= hiOut_d;
      resultHighOe  <= hiOe_d;
    end
  end
endmodule : host_port_output_steering

/* File: rtl/host_port_regs.svh */
// Constants for the host port output steering block
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
`define SEL_CONFIG      3'h0
`define SEL_CONFIG2     3'h1
`define SEL_ANALOG_GAIN 3'h2
`define SEL_ODD_OFFSET  3'h3
`define SEL_EVEN_OFFSET 3'h4
`define SEL_INPUT_OFF   3'h5
`define SEL_RESERVED    3'h6
`define SEL_BAYER       3'h7
`define REG_RESET_VALUE 8'h00
`define NUM_REGS        8
`endif

/* File: rtl/host_port_pkg.sv */
// Types shared by the host port output steering block
package host_port_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_REG_READ,
    MODE_REG_WRITE,
    MODE_RESULT_OUT
  } bus_mode_type;
endpackage : host_port_pkg

/* File: rtl/host_strobe_if.sv */
// Synchronised host strobes passed to the register file
`timescale 1ns/10ps
interface host_strobe_if;
  logic       writeStrobe;
  logic [2:0] regSel;
  logic [7:0] writeData;
  logic [2:0] readSel;
  logic [7:0] readData;
  modport steer (output writeStrobe, output regSel, output writeData, output readSel, input readData);
  modport regs  (input writeStrobe, input regSel, input writeData, input readSel, output readData);
endinterface : host_strobe_if

/* File: rtl/host_reg_file.sv */
// Eight-entry register file written by the host port
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_reg_file (
  input wire logic clk,
  input wire logic resetn,
  host_strobe_if.regs bus
);
  import host_port_pkg::*;
  logic [7:0] regs_q [`NUM_REGS];
  logic [7:0] regs_d [`NUM_REGS];

  // ==========================================
  // Register update
  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (bus.writeStrobe) begin
      regs_d[bus.regSel] = bus.writeData; // R13
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_q[i] <= `REG_RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  assign bus.readData = regs_q[bus.readSel]; // R13
endmodule : host_reg_file

/* File: verification/host_mcu_model.sv */
// Host controller model resolving the shared register bus lanes
`timescale 1ns/10ps
module host_mcu_model (
  input  wire logic       clk,
  input  wire logic       driveEn,
  input  wire logic [7:0] driveData,
  input  wire logic [7:0] hostRegBusOut,
  input  wire logic [7:0] hostRegBusOe,
  output      logic [7:0] hostRegBusIn
);
  logic [7:0] junk_q = 8'h5A;
  // No pull on the lanes, so a floating lane toggles every cycle
  always_ff @(posedge clk) junk_q <= ~junk_q;
  // Both parties driving gives an unknown lane
  always_comb for (int i = 0; i < 8; i++)
    hostRegBusIn[i] = hostRegBusOe[i] ? (driveEn ? 1'bx : hostRegBusOut[i]) : (driveEn ? driveData[i] : junk_q[i]);
endmodule : host_mcu_model

/* File: verification/host_port_properties.sv */
// Port checker for the host port steering block
`timescale 1ns/10ps
module host_port_checker #(
  parameter int RESULT_W = 12
) (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                chip_sel_n,
  input wire logic                rd_strobe_n,
  input wire logic                wr_strobe_n,
  input wire logic                out_en_n,
  input wire logic [2:0]          reg_sel,
  input wire logic [2:0]          bayerCtrlOut,
  input wire logic [7:0]          hostRegBusIn,
  input wire logic [7:0]          hostRegBusOut,
  input wire logic [7:0]          hostRegBusOe,
  input wire logic [3:0]          resultHighOut,
  input wire logic [3:0]          resultHighOe,
  input wire logic [RESULT_W-1:0] convResult
);
  logic [2:0] up_q;
  // Synchroniser contents hold their reset values, not the pins, until a few edges after reset
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  wire ok = up_q == 3'h7;
  wire rdq = ok && !chip_sel_n && !rd_strobe_n && wr_strobe_n;
  wire res = ok && chip_sel_n && !out_en_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence wr7(bit w);
    ok && !chip_sel_n && rd_strobe_n && wr_strobe_n == w && reg_sel == 3'h7 && $stable(hostRegBusIn);
  endsequence
  a_read_drive: assert property (rdq[*4] |-> hostRegBusOe == 8'hFF) else $error("read not driven");
  a_write_float: assert property ((ok && !chip_sel_n && !wr_strobe_n && rd_strobe_n && out_en_n)[*4]
    |-> hostRegBusOe == 8'h00) else $error("bus driven in write");
  a_result_value: assert property ((res && $stable(convResult))[*4]
    |-> {resultHighOut, hostRegBusOut} == (12'(convResult) << (12 - RESULT_W))) else $error("bad result");
  a_result_high: assert property (res[*4] |-> &resultHighOe) else $error("high bits off");
  a_lanes_unused: assert property (res[*4] |-> RESULT_W != 10 || hostRegBusOe[1:0] == 2'h0)
    else $error("lanes 1:0 driven");
  a_idle_float: assert property ((ok && out_en_n && !rdq)[*4]
    |-> hostRegBusOe == 8'h00 && resultHighOe == '0) else $error("not floating");
  a_cs_ignore: assert property ((ok && chip_sel_n)[*5] |=> $stable(bayerCtrlOut)) else $error("deselected write");
  a_write_take: assert property (wr7(0)[*3] ##1 wr7(1)[*6] |-> bayerCtrlOut == hostRegBusIn[2:0])
    else $error("write not captured");
  c_read: cover property (rdq[*4]);
  c_result: cover property (res[*4]);
  c_write: cover property (wr7(0)[*3] ##1 wr7(1));
endmodule : host_port_checker
bind host_port_output_steering host_port_checker #(.RESULT_W(RESULT_W)) chk (
  .clk           (clk),
  .resetn        (resetn),
  .chip_sel_n    (chip_sel_n),
  .rd_strobe_n   (rd_strobe_n),
  .wr_strobe_n   (wr_strobe_n),
  .out_en_n      (out_en_n),
  .reg_sel       (reg_sel),
  .bayerCtrlOut  (bayerCtrlOut),
  .hostRegBusIn  (hostRegBusIn),
  .hostRegBusOut (hostRegBusOut),
  .hostRegBusOe  (hostRegBusOe),
  .resultHighOut (resultHighOut),
  .resultHighOe  (resultHighOe),
  .convResult    (convResult)
);

/* File: verification/host_port_output_steering_bench.sv */
// Self-checking bench for the host port steering block
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_port_output_steering_bench;
  logic clk = 0, resetn = 0, csN = 1, rdN = 1, wrN = 1, oeN = 1, drv = 0;
  logic [2:0] sel = 3'h0, bayer;
  logic [7:0] dat = 8'h00, busIn, busOut, busOe, mem [8];
  logic [11:0] conv = 12'h000;
  logic [3:0] hiOut, hiOe;
  logic lineStart = 0, rstPulse = 0, lvlPulse = 0;
  logic [11:0] gain = 12'h000;
  logic [7:0] offs = 8'h00;
  logic [2:0] bayer10;
  logic [7:0] busIn10, busOut10, busOe10;
  logic [3:0] hiOut10, hiOe10;
  int n_mismatch = 0, check_count = 0;
  always #5 clk = ~clk;
  host_port_output_steering #(.RESULT_W(12)) dut (.clk(clk), .resetn(resetn), .chip_sel_n(csN), .rd_strobe_n(rdN),
    .wr_strobe_n(wrN), .out_en_n(oeN), .reg_sel(sel), .hostRegBusIn(busIn), .hostRegBusOut(busOut),
    .hostRegBusOe(busOe), .resultHighOut(hiOut), .resultHighOe(hiOe), .convResult(conv),
    .gainCoef(gain),
    .offsetCoef(offs),
    .line_start(lineStart),
    .reset_sample_pulse(rstPulse), .level_sample_pulse(lvlPulse), .conv_clk(clk),
    .bayerCtrlOut(bayer));
  host_port_output_steering #(.RESULT_W(10)) dut10 (.clk(clk), .resetn(resetn), .chip_sel_n(csN),
    .rd_strobe_n(rdN), .wr_strobe_n(wrN), .out_en_n(oeN), .reg_sel(sel), .hostRegBusIn(busIn10),
    .hostRegBusOut(busOut10), .hostRegBusOe(busOe10), .resultHighOut(hiOut10), .resultHighOe(hiOe10),
    .convResult(conv[9:0]), .gainCoef(gain[9:0]), .offsetCoef(offs), .line_start(lineStart),
    .reset_sample_pulse(rstPulse), .level_sample_pulse(lvlPulse), .conv_clk(clk), .bayerCtrlOut(bayer10));
  host_mcu_model host (.clk(clk), .driveEn(drv), .driveData(dat), .hostRegBusOut(busOut),
    .hostRegBusOe(busOe), .hostRegBusIn(busIn));
  host_mcu_model host10 (.clk(clk), .driveEn(drv), .driveData(dat), .hostRegBusOut(busOut10),
    .hostRegBusOe(busOe10), .hostRegBusIn(busIn10));
  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Strobes never low together, out_en_n stays high while selected
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    sel = a; dat = d; drv = 1; csN = 0; wrN = 0; cyc(4);
    check(busOe, 8'h00);
    wrN = 1; cyc(7); csN = 1; drv = 0; mem[a] = d; cyc(4);
  endtask : write_reg
  task automatic read_reg(input logic [2:0] a);
    sel = a; csN = 0; rdN = 0; cyc(4);
    check(busOe, 8'hFF);
    check(busOut, mem[a]);
    check(busOut10, mem[a]);
    rdN = 1; cyc(4);
    check(busOe, 8'h00);
    csN = 1; cyc(2);
  endtask : read_reg
  task automatic write_all;
    for (int i = 0; i < 8; i++) read_reg(3'(i));
    for (int i = 0; i < 8; i++) write_reg(3'(i), 8'(8'h11 * i + 8'h0F));
    for (int i = 0; i < 8; i++) read_reg(3'(i));
    check(bayer, mem[7][2:0]);
    check(bayer10, mem[7][2:0]);
  endtask : write_all
  task automatic cs_ignore;
    sel = 3'h7; dat = 8'h71; drv = 1; wrN = 0; cyc(4); wrN = 1; cyc(6); drv = 0;
    check(bayer, mem[7][2:0]);
    check(bayer10, mem[7][2:0]);
    read_reg(3'h7);
  endtask : cs_ignore
  task automatic result_out;
    oeN = 0; rdN = 0;
    foreach (mem[i]) begin
      conv = 12'h5A3 ^ (12'h249 << i);
      gain = 12'hABC ^ conv;
      offs = 8'h3C + 8'(i);
      lineStart = (i == 0);
      rstPulse = 1;
      cyc(1);
      rstPulse = 0;
      lvlPulse = 1;
      cyc(1);
      lvlPulse = 0;
      cyc(2);
      check({hiOut, busOut}, conv);
      check({hiOe, busOe}, 12'hFFF);
      check({hiOut10, busOut10}, {conv[9:0], 2'b00});
      check({hiOe10, busOe10}, 12'hFFC);
    end
    lineStart = 0;
    rdN = 1; oeN = 1; cyc(4);
    check({hiOe, busOe}, 12'h000);
    check({hiOe10, busOe10}, 12'h000);
  endtask : result_out
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    mem = '{default: `REG_RESET_VALUE};
    cyc(2); resetn = 1; cyc(3);
    write_all; cs_ignore; result_out;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule : host_port_output_steering_bench
